// file: hw/buffer_admission_defs.vh
// Purpose: Constants for the packet buffer manager admission and flow thresholds.
// Assumes: Register numbers are word indexes in the switch register space.
// Notes: Levels are counts of 128-byte buffers.
`ifndef BUFFER_ADMISSION_DEFS_VH
`define BUFFER_ADMISSION_DEFS_VH
`define REG_BUFFER_CONFIG 16'h1C00
`define REG_INGRESS_DROP_LEVELS 16'h1C01
`define REG_PAUSE_ASSERT_LEVELS 16'h1C02
`define REG_PAUSE_RELEASE_LEVELS 16'h1C03
`define REG_DROP_COUNT_0 16'h1C05
`define REG_DROP_COUNT_1 16'h1C06
`define REG_DROP_COUNT_2 16'h1C07
`define CFG_RED_DROP 0
`define CFG_YELLOW_DROP 1
`define CFG_PACING_LO 2
`define CFG_PACING_HI 4
`define CFG_FIXED_PRIORITY 5
`define CFG_COUNTER_TEST 6
`define CFG_WIDTH 7
`define CFG_RESET 7'h00
`define LEVEL_LOW_HI 15
`define LEVEL_LOW_LO 8
`define LEVEL_HIGH_HI 7
`define LEVEL_HIGH_LO 0
`define DROP_LEVELS_RESET 16'h4964
`define PAUSE_LEVELS_RESET 16'h213C
`define RESUME_LEVELS_RESET 16'h0307
`define ACTIVE_PORT_BUFFERS 8'h24
`define BUFFER_BYTES 128
`define COUNTER_TEST_PATTERN 32'h07FFFFFC
`define COUNTER_MAX 32'hFFFFFFFF
`define PAUSE_RESUME_VALUE 16'h0001
`endif

// file: hw/packet_buffer_manager.v
// Purpose: Configuration registers, admission, flow control thresholds and drop counters
//    of the packet buffer manager in a three-port switch.
// Assumes: Usage per port is given in 128-byte buffers; one packet arrives per cycle.
// Notes: All outputs are registered; register reads return data one cycle after the strobe.
//    A drop that meets a clearing read of its counter leaves the count at one, so no drop
//    is lost; in counter test mode the pattern is loaded instead.
//    Usage is eight bits per port, so levels above 255 buffers cannot be expressed.
`timescale 1ns/1ps
`include "buffer_admission_defs.vh"
module packet_buffer_manager (
   input wire ref_clk,
   input wire rstn,
   input wire [15:0] reg_addr,
   input wire reg_write,
   input wire reg_read,
   input wire [31:0] reg_wdata,
   output reg [31:0] reg_rdata,
   output reg reg_rvalid,
   input wire [23:0] port_usage,
   input wire pkt_valid,
   input wire [1:0] pkt_port,
   input wire [7:0] pkt_buffers,
   input wire pkt_yellow,
   input wire pkt_red,
   input wire random_discard_hit,
   output reg pkt_admit,
   output reg pkt_drop,
   output reg [2:0] pause_assert,
   output reg [2:0] pause_send,
   output reg [2:0] resume_send,
   output reg [15:0] resume_pause_value,
   output reg fixed_priority,
   output reg [2:0] egress_pacing_enable
);
   reg [`CFG_WIDTH-1:0] buffer_config;
   reg [15:0] ingress_drop_levels;
   reg [15:0] pause_assert_levels;
   reg [15:0] pause_release_levels;
   reg [31:0] drop_count [0:2];
   reg [1:0] active_count;
   reg [7:0] drop_level;
   reg [7:0] pause_level;
   reg [7:0] resume_level;
   reg [8:0] new_usage;
   reg [7:0] own_usage;
   reg drop_now;
   reg [2:0] next_pause;
   reg [31:0] read_word;
   integer i;
   // Each process has its own loop index, so no variable is written from two processes.
   integer k;

   function [7:0] usage_of;
      input [23:0] all;
      input [1:0] port;
      begin
         case (port)
            2'h1: usage_of = all[15:8];
            2'h2: usage_of = all[23:16];
            default: usage_of = all[7:0];
         endcase
      end
   endfunction

   function is_counter;
      input [15:0] addr;
      begin
         is_counter = (addr == `REG_DROP_COUNT_0) || (addr == `REG_DROP_COUNT_1) ||
            (addr == `REG_DROP_COUNT_2);
      end
   endfunction

   // Threshold selection and admission decision.
   // The active count follows the live usage, so the threshold set may change from one
   // cycle to the next; levels are compared directly in buffers, never in bytes.
   always @* begin
      active_count = 2'h0;
      for (i = 0; i < 3; i = i + 1) begin
         if (usage_of(port_usage, i[1:0]) >= `ACTIVE_PORT_BUFFERS) begin
            active_count = active_count + 2'h1;
         end
      end
      if (active_count >= 2'h2) begin
         drop_level = ingress_drop_levels[`LEVEL_LOW_HI:`LEVEL_LOW_LO];
         pause_level = pause_assert_levels[`LEVEL_LOW_HI:`LEVEL_LOW_LO];
      end else begin
         drop_level = ingress_drop_levels[`LEVEL_HIGH_HI:`LEVEL_HIGH_LO];
         pause_level = pause_assert_levels[`LEVEL_HIGH_HI:`LEVEL_HIGH_LO];
      end
      if (active_count >= 2'h2) begin
         resume_level = pause_release_levels[`LEVEL_LOW_HI:`LEVEL_LOW_LO];
      end else begin
         resume_level = pause_release_levels[`LEVEL_HIGH_HI:`LEVEL_HIGH_LO];
      end
      own_usage = usage_of(port_usage, pkt_port);
      new_usage = {1'b0, own_usage} + {1'b0, pkt_buffers};
      drop_now = new_usage > {1'b0, drop_level};
      if (buffer_config[`CFG_RED_DROP] && pkt_red) begin
         drop_now = 1'b1;
      end
      if (buffer_config[`CFG_YELLOW_DROP] && pkt_yellow && random_discard_hit) begin
         drop_now = 1'b1;
      end
      // A port is released only while it is paused and at or below the resume level; pause
      // is tested first so it wins when one usage meets both levels.
      next_pause = pause_assert;
      for (i = 0; i < 3; i = i + 1) begin
         if (usage_of(port_usage, i[1:0]) >= pause_level) begin
            next_pause[i] = 1'b1;
         end else if (pause_assert[i] && usage_of(port_usage, i[1:0]) <= resume_level) begin
            next_pause[i] = 1'b0;
         end
      end
   end

   // Register read mux; unmapped addresses read as zero and writes to counters are ignored.
   always @* begin
      case (reg_addr)
         `REG_BUFFER_CONFIG: read_word = {25'h0, buffer_config};
         `REG_INGRESS_DROP_LEVELS: read_word = {16'h0000, ingress_drop_levels};
         `REG_PAUSE_ASSERT_LEVELS: read_word = {16'h0000, pause_assert_levels};
         `REG_PAUSE_RELEASE_LEVELS: read_word = {16'h0000, pause_release_levels};
         `REG_DROP_COUNT_0: read_word = drop_count[0];
         `REG_DROP_COUNT_1: read_word = drop_count[1];
         `REG_DROP_COUNT_2: read_word = drop_count[2];
         default: read_word = 32'h00000000;
      endcase
   end

   // Registers, drop counters and every output; all outputs leave from flip-flops.
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         buffer_config <= `CFG_RESET;
         ingress_drop_levels <= `DROP_LEVELS_RESET;
         pause_assert_levels <= `PAUSE_LEVELS_RESET;
         pause_release_levels <= `RESUME_LEVELS_RESET;
         for (k = 0; k < 3; k = k + 1) begin
            drop_count[k] <= 32'h00000000;
         end
         reg_rdata <= 32'h00000000;
         reg_rvalid <= 1'b0;
         pkt_admit <= 1'b0;
         pkt_drop <= 1'b0;
         pause_assert <= 3'h0;
         pause_send <= 3'h0;
         resume_send <= 3'h0;
         resume_pause_value <= 16'h0000;
         fixed_priority <= 1'b0;
         egress_pacing_enable <= 3'h0;
      end else begin
         if (reg_write) begin
            case (reg_addr)
               `REG_BUFFER_CONFIG: buffer_config <= reg_wdata[`CFG_WIDTH-1:0];
               `REG_INGRESS_DROP_LEVELS: ingress_drop_levels <= reg_wdata[15:0];
               `REG_PAUSE_ASSERT_LEVELS: pause_assert_levels <= reg_wdata[15:0];
               `REG_PAUSE_RELEASE_LEVELS: pause_release_levels <= reg_wdata[15:0];
               default: ;
            endcase
         end
         // Read data holds until the next read, so software may take it late.
         reg_rvalid <= reg_read;
         if (reg_read) begin
            reg_rdata <= read_word;
         end
         for (k = 0; k < 3; k = k + 1) begin
            // clear on read, test pattern load and saturating drop count
            // A drop in the read cycle is counted after the clear, so it is lost only in counter test mode.
            // Saturation holds the count at all ones rather than wrapping to zero.
            if (reg_read && is_counter(reg_addr) && reg_addr[1:0] == k[1:0] + 2'h1) begin
               if (buffer_config[`CFG_COUNTER_TEST]) begin
                  drop_count[k] <= `COUNTER_TEST_PATTERN;
               end else if (pkt_valid && drop_now && pkt_port == k[1:0]) begin
                  drop_count[k] <= 32'h00000001;
               end else begin
                  drop_count[k] <= 32'h00000000;
               end
            end else if (pkt_valid && drop_now && pkt_port == k[1:0] &&
                  drop_count[k] != `COUNTER_MAX) begin
               drop_count[k] <= drop_count[k] + 32'h00000001;
            end
         end
         pkt_admit <= pkt_valid && !drop_now;
         pkt_drop <= pkt_valid && drop_now;
         pause_assert <= next_pause;
         pause_send <= next_pause & ~pause_assert;
         resume_send <= pause_assert & ~next_pause;
         resume_pause_value <= `PAUSE_RESUME_VALUE;
         fixed_priority <= buffer_config[`CFG_FIXED_PRIORITY];
         egress_pacing_enable <= buffer_config[`CFG_PACING_HI:`CFG_PACING_LO];
      end
   end
endmodule // packet_buffer_manager

// file: dv/packet_buffer_manager_monitor.sv
// Purpose: Port-level checks of the packet buffer manager.
// Assumes: The config register is mirrored here from writes seen on the ports.
// Notes: Flow control is watched on port 0 only, to keep this small.
`timescale 1ns/1ps
`include "buffer_admission_defs.vh"
module buffer_admission_monitor (
   input wire ref_clk,
   input wire rstn,
   input wire [15:0] reg_addr,
   input wire reg_write,
   input wire [31:0] reg_wdata,
   input wire pkt_valid,
   input wire pkt_red,
   input wire pkt_admit,
   input wire pkt_drop,
   input wire [2:0] pause_assert,
   input wire [2:0] pause_send,
   input wire [2:0] resume_send,
   input wire [15:0] resume_pause_value,
   input wire fixed_priority,
   input wire [2:0] egress_pacing_enable
);
   reg [6:0] cfg;
   wire cfg_wr = reg_write && reg_addr == 16'h1C00;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) cfg <= 7'h00;
      else if (cfg_wr) cfg <= reg_wdata[6:0];
   end
   pacing_copy_a: assert property (cfg_wr |=> ##1
      egress_pacing_enable == cfg[4:2]) else $error("pacing enables differ from config");
   priority_copy_a: assert property (cfg_wr |=> ##1
      fixed_priority == cfg[5]) else $error("servicing order differs from config");
   red_drop_a: assert property (pkt_valid && pkt_red && cfg[0] |=> pkt_drop)
      else $error("red packet not dropped");
   one_answer_a: assert property (pkt_valid |=> pkt_admit ^ pkt_drop)
      else $error("packet answer not exactly one");
   quiet_answer_a: assert property (!pkt_valid |=> !(pkt_admit || pkt_drop))
      else $error("answer without packet");
   pause_entry_a: assert property (pause_send[0] ==
      (pause_assert[0] && !$past(pause_assert[0]))) else $error("pause pulse wrong");
   resume_hyst_a: assert property (resume_send[0] |->
      !pause_assert[0] && $past(pause_assert[0])) else $error("resume without pause");
   resume_value_a: assert property ($past(rstn) |->
      resume_pause_value == 16'h0001) else $error("resume pause value not one");
endmodule // buffer_admission_monitor
bind packet_buffer_manager buffer_admission_monitor i_mon (
   .ref_clk(ref_clk),
   .rstn(rstn),
   .reg_addr(reg_addr),
   .reg_write(reg_write),
   .reg_wdata(reg_wdata),
   .pkt_valid(pkt_valid),
   .pkt_red(pkt_red),
   .pkt_admit(pkt_admit),
   .pkt_drop(pkt_drop),
   .pause_assert(pause_assert),
   .pause_send(pause_send),
   .resume_send(resume_send),
   .resume_pause_value(resume_pause_value),
   .fixed_priority(fixed_priority),
   .egress_pacing_enable(egress_pacing_enable)
);

// file: dv/test_packet_buffer_manager.sv
// Purpose: Self-checking bench of the packet buffer manager.
// Assumes: Inputs change at the falling edge, outputs are settled there.
// Notes: Counter saturation is not reached; it needs 2^32 - 1 drops from zero.
`timescale 1ns/1ps
module test_packet_buffer_manager;
   reg ref_clk = 0, rstn = 0, reg_write = 0, reg_read = 0, pkt_valid = 0;
   reg pkt_yellow = 0, pkt_red = 0, random_discard_hit = 0;
   reg [15:0] reg_addr = 16'h0000;
   reg [31:0] reg_wdata = 32'h00000000;
   reg [23:0] port_usage = 24'h000000;
   reg [1:0] pkt_port = 2'h0;
   reg [7:0] pkt_buffers = 8'h00;
   wire [31:0] reg_rdata;
   wire reg_rvalid, pkt_admit, pkt_drop, fixed_priority;
   wire [2:0] pause_assert, pause_send, resume_send, egress_pacing_enable;
   wire [15:0] resume_pause_value;
   integer n_fail = 0, checks = 0;
   packet_buffer_manager i_dut (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .reg_addr(reg_addr),
      .reg_write(reg_write),
      .reg_read(reg_read),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid),
      .port_usage(port_usage),
      .pkt_valid(pkt_valid),
      .pkt_port(pkt_port),
      .pkt_buffers(pkt_buffers),
      .pkt_yellow(pkt_yellow),
      .pkt_red(pkt_red),
      .random_discard_hit(random_discard_hit),
      .pkt_admit(pkt_admit),
      .pkt_drop(pkt_drop),
      .pause_assert(pause_assert),
      .pause_send(pause_send),
      .resume_send(resume_send),
      .resume_pause_value(resume_pause_value),
      .fixed_priority(fixed_priority),
      .egress_pacing_enable(egress_pacing_enable)
   );
   initial forever #10 ref_clk = ~ref_clk;
   task chk(input string name, input [31:0] exp, input [31:0] seen);
      checks = checks + 1;
      if (seen !== exp) begin
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
         n_fail = n_fail + 1;
      end
   endtask
   task rdchk(input string name, input [15:0] a, input [31:0] exp);
      reg_addr = a;
      reg_read = 1;
      @(negedge ref_clk);
      reg_read = 0;
      chk("reg_rvalid", 32'h00000001, {31'h0, reg_rvalid});
      chk(name, exp, reg_rdata);
      @(negedge ref_clk);
   endtask
   task wr(input [15:0] a, input [31:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_write = 1;
      @(negedge ref_clk);
      reg_write = 0;
      @(negedge ref_clk);
   endtask
   // A second falling edge lets the strobe rest low before the next packet.
   task pkt(input [7:0] b, input y, input r, input h, input [31:0] dr);
      {pkt_buffers, pkt_yellow, pkt_red, random_discard_hit, pkt_valid} = {b, y, r, h, 1'b1};
      @(negedge ref_clk);
      pkt_valid = 0;
      chk("pkt_drop", dr, {31'h0, pkt_drop});
      chk("pkt_admit", dr ^ 32'h00000001, {31'h0, pkt_admit});
      @(negedge ref_clk);
   endtask
   task t_reset;
      rdchk("config", 16'h1C00, 32'h00000000);
      rdchk("drop_levels", 16'h1C01, 32'h00004964);
      rdchk("pause_levels", 16'h1C02, 32'h0000213C);
      rdchk("resume_levels", 16'h1C03, 32'h00000307);
      rdchk("unmapped", 16'h1C10, 32'h00000000);
      $display("test reset done");
   endtask
   task t_cfg;
      wr(16'h1C00, 32'h00000034);
      chk("fixed_priority", 32'h00000001, {31'h0, fixed_priority});
      chk("pacing", 32'h00000005, {29'h0, egress_pacing_enable});
      wr(16'h1C00, 32'h0000000C);
      chk("pacing", 32'h00000003, {29'h0, egress_pacing_enable});
      chk("fixed_priority", 32'h00000000, {31'h0, fixed_priority});
      rdchk("config", 16'h1C00, 32'h0000000C);
      $display("test config done");
   endtask
   task t_adm;
      port_usage = 24'h000030;
      pkt(8'h34, 0, 0, 0, 0);
      pkt(8'h35, 0, 0, 0, 1);
      port_usage = 24'h002430;
      pkt(8'h19, 0, 0, 0, 0);
      pkt(8'h1A, 0, 0, 0, 1);
      port_usage = 24'h000000;
      pkt(8'h01, 1, 1, 1, 0);
      wr(16'h1C00, 32'h00000003);
      pkt(8'h01, 1, 0, 0, 0);
      pkt(8'h01, 1, 0, 1, 1);
      pkt(8'h01, 0, 1, 0, 1);
      $display("test admission done");
   endtask
   task t_cnt;
      rdchk("drop_count", 16'h1C05, 32'h00000004);
      rdchk("drop_count", 16'h1C05, 32'h00000000);
      wr(16'h1C00, 32'h00000041);
      pkt(8'h01, 0, 1, 0, 1);
      rdchk("drop_count", 16'h1C05, 32'h00000001);
      rdchk("drop_count", 16'h1C05, 32'h07FFFFFC);
      wr(16'h1C00, 32'h00000000);
      $display("test counters done");
   endtask
   task t_pause;
      port_usage = 24'h00003B;
      @(negedge ref_clk);
      chk("pause_assert", 32'h00000000, {29'h0, pause_assert});
      port_usage = 24'h00003C;
      @(negedge ref_clk);
      chk("pause_send", 32'h00000001, {29'h0, pause_send});
      port_usage = 24'h000008;
      @(negedge ref_clk);
      chk("pause_assert", 32'h00000001, {29'h0, pause_assert});
      port_usage = 24'h000007;
      @(negedge ref_clk);
      chk("resume_send", 32'h00000001, {29'h0, resume_send});
      chk("resume_value", 32'h00000001, {16'h0, resume_pause_value});
      $display("test pause done");
   endtask
   // Ports 1 and 2 use their own usage byte and counter; only port 2's pause bit is driven and checked.
   task t_ports;
      port_usage = 24'h3C0000;
      pkt_port = 2'h2;
      pkt(8'h28, 0, 0, 0, 0);
      chk("pause_assert", 32'h00000004, {29'h0, pause_assert});
      pkt(8'h29, 0, 0, 0, 1);
      pkt_port = 2'h1;
      pkt(8'h65, 0, 0, 0, 1);
      pkt_port = 2'h0;
      rdchk("drop_count_1", 16'h1C06, 32'h00000001);
      rdchk("drop_count_2", 16'h1C07, 32'h00000001);
      port_usage = 24'h000000;
      @(negedge ref_clk);
      chk("resume_send", 32'h00000004, {29'h0, resume_send});
      $display("test ports done");
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // The tests need about 70 cycles; 5000 cycles leaves ample margin.
   initial begin
      #100000;
      n_fail = n_fail + 1;
      finish_test;
   end
   initial begin
      repeat (8) @(negedge ref_clk);
      rstn = 1;
      t_reset;
      t_cfg;
      t_adm;
      t_cnt;
      t_pause;
      t_ports;
      finish_test;
   end
endmodule // test_packet_buffer_manager
